// [design/gxp_pkg.sv]
// package: register map, reset values, timing counts and state carriers of the gpio expander
package gxp_pkg;

	localparam int NPIN = 8;

	typedef logic [NPIN-1:0] gxp_byte_t;

	// register selector values carried in command bits 6:1
	localparam logic [5:0] REG_PIN_STATE       = 6'h00;
	localparam logic [5:0] REG_OUTPUT_LEVEL    = 6'h01;
	localparam logic [5:0] REG_INPUT_INVERT    = 6'h02;
	localparam logic [5:0] REG_PIN_DIRECTION   = 6'h03;
	localparam logic [5:0] REG_PULLUP_ENABLE   = 6'h04;
	localparam logic [5:0] REG_IRQ_ENABLE      = 6'h05;
	localparam logic [5:0] REG_OUTPUT_HIZ      = 6'h06;
	localparam logic [5:0] REG_IRQ_STATUS      = 6'h07;
	localparam logic [5:0] REG_RISE_IRQ_SELECT = 6'h08;
	localparam logic [5:0] REG_FALL_IRQ_SELECT = 6'h09;
	localparam logic [5:0] REG_GLITCH_FILTER   = 6'h0A;

	localparam gxp_byte_t RST_OUTPUT_LEVEL    = 8'hFF;
	localparam gxp_byte_t RST_INPUT_INVERT    = 8'h00;
	localparam gxp_byte_t RST_PIN_DIRECTION   = 8'hFF;
	localparam gxp_byte_t RST_PULLUP_ENABLE   = 8'h00;
	localparam gxp_byte_t RST_IRQ_ENABLE      = 8'h00;
	localparam gxp_byte_t RST_OUTPUT_HIZ      = 8'h00;
	localparam gxp_byte_t RST_IRQ_STATUS      = 8'h00;
	localparam gxp_byte_t RST_RISE_IRQ_SELECT = 8'h00;
	localparam gxp_byte_t RST_FALL_IRQ_SELECT = 8'h00;
	localparam gxp_byte_t RST_GLITCH_FILTER   = 8'hFF;
	localparam gxp_byte_t ALL_PINS            = 8'hFF;
	localparam gxp_byte_t NO_PINS             = 8'h00;

	// serial frame: rising-edge counts at which fields are complete
	localparam logic [4:0] LNK_ADDR_CNT  = 5'h06;
	localparam logic [4:0] LNK_CMD_CNT   = 5'h08;
	localparam logic [4:0] LNK_LAST_CNT  = 5'h0F;
	localparam logic [4:0] LNK_FRAME_CNT = 5'h10;

	// input filter timing
	localparam int CLK_SYS_NS    = 100;
	localparam int FLT_REJECT_NS = 225;
	localparam int FLT_ACCEPT_NS = 1075;
	localparam int FLT_MIN_CYC   = (FLT_REJECT_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int FLT_MAX_CYC   = FLT_ACCEPT_NS / CLK_SYS_NS;
	localparam int FLT_CYC_DEF   = (FLT_MIN_CYC + FLT_MAX_CYC) / 2;
	localparam int FLT_CNT_W     = 4;

	typedef struct packed {
		gxp_byte_t output_level;
		gxp_byte_t input_invert;
		gxp_byte_t pin_direction;
		gxp_byte_t pullup_enable;
		gxp_byte_t irq_enable;
		gxp_byte_t output_hiz;
		gxp_byte_t irq_status;
		gxp_byte_t rise_irq_select;
		gxp_byte_t fall_irq_select;
		gxp_byte_t glitch_filter_enable;
	} gxp_regs_t;

	typedef struct packed {
		gxp_regs_t                             regs;
		gxp_byte_t                             sync1;
		gxp_byte_t                             sync2;
		gxp_byte_t                             flt_lvl;
		logic [NPIN-1:0][FLT_CNT_W-1:0]        flt_cnt;
		gxp_byte_t                             det_lvl;
		gxp_byte_t                             ref_lvl;
		logic [2:0]                            rq_s;
		logic [2:0]                            wq_s;
		gxp_byte_t                             rd_hold;
		gxp_byte_t                             pin_oe;
		logic                                  irq_oe;
	} gxp_sys_t;

	typedef struct packed {
		logic [4:0]  bitcnt;
		logic [14:0] shift;
		logic        rd_cmd;
		logic [5:0]  addr;
		logic        rd_req;
		gxp_byte_t   wdata;
		logic        wr_req;
	} gxp_lnk_t;

	typedef struct packed {
		gxp_byte_t shift;
		logic      oe;
	} gxp_so_t;

endpackage : gxp_pkg

// [design/gxp_port.sv]
// gpio expander port: serial register access, pin control, filtering and interrupt status
`timescale 1ns/1ps

// Notes on behaviour
// - pin state shows input level, maybe inverted
// - pin state read clears pending interrupts
// - output pins read back output level register
// - writes to pin state change nothing
// - bit n of every register is pin n
// - output level drives pins, reads back written
// - invert bit one shows inverted input level
// - direction zero output, one input; reset inputs
// - pull-up bit one enables; reset all off
// - interrupt enable gates pins; reset all off
// - output pins never raise interrupts
// - hiz bit one floats output pin
// - status read-only, one per pending pin
// - rise select interrupts on low-to-high
// - fall select on high-to-low; both either
// - no select: any edge, clear on revert
// - any select set: only read clears
// - filter passes long levels, rejects short pulses
// - filter bit zero bypasses the filter
// - command byte: read bit, selector, reserved
// - eleven registers at selectors zero to ten
module gxp_port #(
	parameter int FLT_CYC = gxp_pkg::FLT_CYC_DEF
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	input  wire logic              spi_clk_i,
	input  wire logic              spi_cs_n_i,
	input  wire logic              spi_si_i,
	output logic                   spi_so_o,
	output logic                   spi_so_oe_o,
	input  wire gxp_pkg::gxp_byte_t io_pins_i,
	output gxp_pkg::gxp_byte_t     io_pins_o,
	output gxp_pkg::gxp_byte_t     io_pins_oe_o,
	output gxp_pkg::gxp_byte_t     pullup_en_o,
	output logic                   irq_n_o,
	output logic                   irq_n_oe_o
);
	import gxp_pkg::*;

	// threshold must reject the short pulse and still accept the long one
	if (FLT_CYC <= FLT_MIN_CYC || FLT_CYC > FLT_MAX_CYC || FLT_CYC >= (1 << FLT_CNT_W)) begin : g_chk
		$error("gxp_port: FLT_CYC outside the accepted filter window");
	end

	localparam logic [FLT_CNT_W-1:0] FLT_LAST = FLT_CNT_W'(FLT_CYC - 1);

	gxp_sys_t s_q;
	gxp_sys_t s_d;
	gxp_lnk_t l_q;
	gxp_lnk_t l_d;
	gxp_so_t  o_q;
	gxp_so_t  o_d;

	logic      rd_evt;
	logic      wr_evt;
	logic      pin_rd;
	gxp_byte_t lvl_now;
	gxp_byte_t rise_v;
	gxp_byte_t fall_v;
	gxp_byte_t sel_any;
	gxp_byte_t set_v;
	gxp_byte_t clr_v;
	gxp_byte_t pin_state_v;
	gxp_byte_t mism;
	gxp_byte_t wr_data_w;
	gxp_byte_t byp_evt;
	gxp_byte_t rise_evt;

	// ---------------- link side, on the serial clock ----------------

	always_comb begin
		l_d = l_q;
		if (l_q.bitcnt != LNK_FRAME_CNT) begin
			l_d.bitcnt = l_q.bitcnt + 5'h01;
			l_d.shift  = {l_q.shift[13:0], spi_si_i};
		end
		if (l_q.bitcnt == LNK_ADDR_CNT) begin
			l_d.rd_cmd = l_q.shift[5];
			l_d.addr   = {l_q.shift[4:0], spi_si_i};
			l_d.rd_req = l_q.shift[5];
		end
		if (l_q.bitcnt == LNK_LAST_CNT && !l_q.rd_cmd) begin
			l_d.wdata  = {l_q.shift[6:0], spi_si_i};
			l_d.wr_req = 1'b1;
		end
	end

	// chip select ends the frame; requests are levels that fall with it
	always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	always_comb begin
		o_d = o_q;
		if (l_q.rd_cmd && l_q.bitcnt == LNK_CMD_CNT && !o_q.oe) begin
			// read byte is held still by the sys side once the request was seen
			o_d.shift = s_q.rd_hold;
			o_d.oe    = 1'b1;
		end else if (o_q.oe) begin
			o_d.shift = {o_q.shift[6:0], 1'b0};
		end
	end

	always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			o_q <= '0;
		end else begin
			o_q <= o_d;
		end
	end

	assign spi_so_o    = o_q.shift[7];
	assign spi_so_oe_o = o_q.oe;

	// ---------------- system side ----------------

	assign rd_evt    = s_q.rq_s[1] & ~s_q.rq_s[2];
	assign wr_evt    = s_q.wq_s[1] & ~s_q.wq_s[2];
	assign pin_rd    = rd_evt && (l_q.addr == REG_PIN_STATE);
	assign wr_data_w = l_q.wdata;
	assign mism      = s_q.sync2 ^ s_q.flt_lvl;

	assign lvl_now = (s_q.regs.glitch_filter_enable & s_q.flt_lvl)
		| (~s_q.regs.glitch_filter_enable & s_q.sync2);
	assign rise_v  = lvl_now & ~s_q.det_lvl;
	assign fall_v  = ~lvl_now & s_q.det_lvl;
	assign sel_any = s_q.regs.rise_irq_select | s_q.regs.fall_irq_select;

	assign set_v = ((rise_v & s_q.regs.rise_irq_select)
		| (fall_v & s_q.regs.fall_irq_select)
		| ((rise_v | fall_v) & ~sel_any))
		& s_q.regs.irq_enable & s_q.regs.pin_direction;

	assign clr_v = (pin_rd ? ALL_PINS : NO_PINS) | (~sel_any & ~(lvl_now ^ s_q.ref_lvl));

	assign pin_state_v = (s_q.regs.pin_direction & (s_q.sync2 ^ s_q.regs.input_invert))
		| (~s_q.regs.pin_direction & s_q.regs.output_level);

	always_comb begin
		s_d = s_q;
		s_d.sync1 = io_pins_i;
		s_d.sync2 = s_q.sync1;
		s_d.rq_s  = {s_q.rq_s[1:0], l_q.rd_req};
		s_d.wq_s  = {s_q.wq_s[1:0], l_q.wr_req};

		for (int i = 0; i < NPIN; i++) begin
			if (!mism[i]) begin
				s_d.flt_cnt[i] = '0;
			end else if (s_q.flt_cnt[i] == FLT_LAST) begin
				s_d.flt_lvl[i] = s_q.sync2[i];
				s_d.flt_cnt[i] = '0;
			end else begin
				s_d.flt_cnt[i] = s_q.flt_cnt[i] + 1'b1;
			end
		end

		s_d.det_lvl = lvl_now;
		// status follows pending, new event wins
		s_d.regs.irq_status = (s_q.regs.irq_status & ~clr_v) | set_v;

		if (pin_rd) begin
			s_d.ref_lvl = lvl_now;
		end

		if (rd_evt) begin
			case (l_q.addr)
				REG_PIN_STATE:       s_d.rd_hold = pin_state_v;
				REG_OUTPUT_LEVEL:    s_d.rd_hold = s_q.regs.output_level;
				REG_INPUT_INVERT:    s_d.rd_hold = s_q.regs.input_invert;
				REG_PIN_DIRECTION:   s_d.rd_hold = s_q.regs.pin_direction;
				REG_PULLUP_ENABLE:   s_d.rd_hold = s_q.regs.pullup_enable;
				REG_IRQ_ENABLE:      s_d.rd_hold = s_q.regs.irq_enable;
				REG_OUTPUT_HIZ:      s_d.rd_hold = s_q.regs.output_hiz;
				REG_IRQ_STATUS:      s_d.rd_hold = s_q.regs.irq_status;
				REG_RISE_IRQ_SELECT: s_d.rd_hold = s_q.regs.rise_irq_select;
				REG_FALL_IRQ_SELECT: s_d.rd_hold = s_q.regs.fall_irq_select;
				REG_GLITCH_FILTER:   s_d.rd_hold = s_q.regs.glitch_filter_enable;
				default:             s_d.rd_hold = NO_PINS;
			endcase
		end

		// pin state and status not writable
		if (wr_evt) begin
			case (l_q.addr)
				REG_OUTPUT_LEVEL:    s_d.regs.output_level         = l_q.wdata;
				REG_INPUT_INVERT:    s_d.regs.input_invert         = l_q.wdata;
				REG_PIN_DIRECTION:   s_d.regs.pin_direction        = l_q.wdata;
				REG_PULLUP_ENABLE:   s_d.regs.pullup_enable        = l_q.wdata;
				REG_IRQ_ENABLE:      s_d.regs.irq_enable           = l_q.wdata;
				REG_OUTPUT_HIZ:      s_d.regs.output_hiz           = l_q.wdata;
				REG_RISE_IRQ_SELECT: s_d.regs.rise_irq_select      = l_q.wdata;
				REG_FALL_IRQ_SELECT: s_d.regs.fall_irq_select      = l_q.wdata;
				REG_GLITCH_FILTER:   s_d.regs.glitch_filter_enable = l_q.wdata;
				default:             s_d.regs.output_level         = s_q.regs.output_level;
			endcase
		end

		s_d.pin_oe = ~s_d.regs.pin_direction & ~s_d.regs.output_hiz;
		s_d.irq_oe = |s_d.regs.irq_status;

		if (!rst_n_i) begin
			s_d = '0;
			s_d.regs.pin_direction        = RST_PIN_DIRECTION;
			s_d.regs.output_level         = RST_OUTPUT_LEVEL;
			s_d.regs.input_invert         = RST_INPUT_INVERT;
			s_d.regs.pullup_enable        = RST_PULLUP_ENABLE;
			s_d.regs.irq_enable           = RST_IRQ_ENABLE;
			s_d.regs.output_hiz           = RST_OUTPUT_HIZ;
			s_d.regs.irq_status           = RST_IRQ_STATUS;
			s_d.regs.rise_irq_select      = RST_RISE_IRQ_SELECT;
			s_d.regs.fall_irq_select      = RST_FALL_IRQ_SELECT;
			s_d.regs.glitch_filter_enable = RST_GLITCH_FILTER;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		s_q <= s_d;
	end

	assign io_pins_o    = s_q.regs.output_level;
	assign io_pins_oe_o = s_q.pin_oe;
	assign pullup_en_o  = s_q.regs.pullup_enable;
	// open drain: the wire is only ever pulled low
	assign irq_n_o      = 1'b0;
	assign irq_n_oe_o   = s_q.irq_oe;

	// ---------------- assertions ----------------

	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_mism0;
		!mism[0] ##1 mism[0] [*6];
	endsequence

	sequence s_wr_out;
		wr_evt && (l_q.addr == REG_OUTPUT_LEVEL);
	endsequence

	property p_reset_dir;
		@(posedge clk_sys_i) disable iff (1'b0)
		!rst_n_i |=> (s_q.regs.pin_direction == RST_PIN_DIRECTION) && (io_pins_oe_o == NO_PINS)
			&& (irq_n_oe_o == 1'b0) && (pullup_en_o == NO_PINS);
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("reset values wrong");

	// status is left out: pins may still set or clear it while the write lands
	property p_pin_state_wr;
		wr_evt && (l_q.addr == REG_PIN_STATE)
			|=> $stable({s_q.regs.output_level, s_q.regs.input_invert, s_q.regs.pin_direction})
			&& $stable({s_q.regs.pullup_enable, s_q.regs.irq_enable, s_q.regs.output_hiz})
			&& $stable({s_q.regs.rise_irq_select, s_q.regs.fall_irq_select,
				s_q.regs.glitch_filter_enable});
	endproperty
	a_pin_state_wr: assert property (p_pin_state_wr) else $error("pin state write changed state");

	property p_out_no_irq;
		((s_q.regs.irq_status & ~$past(s_q.regs.irq_status) & ~$past(s_q.regs.pin_direction))
			== NO_PINS);
	endproperty
	a_out_no_irq: assert property (p_out_no_irq) else $error("output pin raised interrupt");

	property p_irq_pin;
		(s_q.regs.irq_status != NO_PINS) |-> irq_n_oe_o ##1 ($past(s_q.regs.irq_status) == NO_PINS
			|| irq_n_oe_o || $past(pin_rd) || $past(clr_v) != NO_PINS);
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("irq not pulled while pending");

	property p_select_hold;
		!pin_rd && (sel_any == ALL_PINS) |=> ($past(s_q.regs.irq_status) & ~s_q.regs.irq_status)
			== NO_PINS;
	endproperty
	a_select_hold: assert property (p_select_hold) else $error("status cleared without read");

	property p_read_clear;
		pin_rd && (set_v == NO_PINS) |=> (s_q.regs.irq_status == NO_PINS) && !irq_n_oe_o;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("pin state read did not clear");

	property p_out_echo;
		pin_rd && !wr_evt |=> ((s_q.rd_hold ^ s_q.regs.output_level) & ~s_q.regs.pin_direction)
			== NO_PINS;
	endproperty
	a_out_echo: assert property (p_out_echo) else $error("output bit not echoed");

	property p_hiz_float;
		((io_pins_oe_o & (s_q.regs.output_hiz | s_q.regs.pin_direction)) == NO_PINS);
	endproperty
	a_hiz_float: assert property (p_hiz_float) else $error("floated pin driven");

	property p_filter_accept;
		s_mism0 |=> (s_q.flt_lvl[0] == $past(s_q.sync2[0]));
	endproperty
	a_filter_accept: assert property (p_filter_accept) else $error("filter did not accept");

	property p_filter_reject;
		$changed(s_q.flt_lvl[0]) |-> $past(mism[0], 1) && $past(mism[0], 3) && $past(mism[0], 5);
	endproperty
	a_filter_reject: assert property (p_filter_reject) else $error("short pulse passed filter");

	property p_out_write;
		s_wr_out |=> (s_q.regs.output_level == $past(wr_data_w)) ##1
			(io_pins_o == $past(wr_data_w, 2));
	endproperty
	a_out_write: assert property (p_out_write) else $error("output level not written");

	// helper masks for the per-pin event checks below
	assign byp_evt  = ~s_q.regs.glitch_filter_enable & s_q.regs.irq_enable
		& s_q.regs.pin_direction & (s_q.sync2 ^ s_q.det_lvl) & ~sel_any;
	assign rise_evt = rise_v & s_q.regs.rise_irq_select & s_q.regs.irq_enable
		& s_q.regs.pin_direction;

	property p_irq_release;
		irq_n_oe_o == (s_q.regs.irq_status != NO_PINS);
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("irq pull mismatch");

	property p_invert;
		pin_rd && !wr_evt |=> ((s_q.rd_hold ^ $past(s_q.sync2) ^ s_q.regs.input_invert)
			& s_q.regs.pin_direction) == NO_PINS;
	endproperty
	a_invert: assert property (p_invert) else $error("input polarity wrong");

	property p_revert_clear;
		(sel_any == NO_PINS) && (set_v == NO_PINS) && (lvl_now == s_q.ref_lvl)
			|=> s_q.regs.irq_status == NO_PINS;
	endproperty
	a_revert_clear: assert property (p_revert_clear) else $error("revert did not clear");

	property p_bypass_edge;
		(byp_evt != NO_PINS) |=> (s_q.regs.irq_status & $past(byp_evt)) == $past(byp_evt);
	endproperty
	a_bypass_edge: assert property (p_bypass_edge) else $error("bypassed edge lost");

	property p_rise_set;
		(rise_evt != NO_PINS) |=> (s_q.regs.irq_status & $past(rise_evt)) == $past(rise_evt);
	endproperty
	a_rise_set: assert property (p_rise_set) else $error("rising edge lost");

	property p_status_read;
		rd_evt && (l_q.addr == REG_IRQ_STATUS) |=> s_q.rd_hold == $past(s_q.regs.irq_status);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

endmodule : gxp_port

// [dv/gxp_spi_host.sv]
// serial master model that reaches the expander registers, one register per frame
`timescale 1ns/1ps
module gxp_spi_host (
	output logic      spi_clk_o,
	output logic      spi_cs_n_o,
	output logic      spi_si_o,
	input  wire logic spi_so_i
);
	import gxp_pkg::*;

	// link clock stands still low outside frames
	initial begin
		spi_clk_o = 1'b0;
		spi_cs_n_o = 1'b0;
		spi_si_o = 1'b0;
		// a clean rising select edge clears the link state before the first frame
		#20;
		spi_cs_n_o = 1'b1;
	end

	task automatic xfer(input logic rd, input logic [5:0] sel, input logic rsv,
		input gxp_byte_t wd, output gxp_byte_t rdat);
		logic [15:0] f;
		f = {rd, sel, rsv, wd};
		rdat = 8'h00;
		#37;
		spi_cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_si_o <= f[i];
			#80;
			spi_clk_o <= 1'b1;
			if (i < 8) rdat[i] = spi_so_i;
			// stretch after the selector so the read value can cross into this domain
			#(i == 9 ? 480 : 80);
			spi_clk_o <= 1'b0;
		end
		#80;
		// released data line must not keep its last level
		spi_si_o <= ~spi_si_o;
		#400;
		spi_cs_n_o <= 1'b1;
		#400;
	endtask : xfer
endmodule : gxp_spi_host

// [dv/gxp_port_tb_top.sv]
// self-checking bench of the gpio expander port
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module gxp_port_tb_top;
	import gxp_pkg::*;
	logic      clk_sys_i = 1'b0;
	logic      rst_n_i   = 1'b0;
	wire logic spi_clk, spi_cs_n, spi_si;
	logic      spi_so, spi_so_oe, irq_n, irq_n_oe;
	gxp_byte_t ext_q     = 8'h00;
	gxp_byte_t pins_o, pins_oe, pu_en;
	wire gxp_byte_t pin_lvl  = (pins_oe & pins_o) | (~pins_oe & ext_q);
	// undriven serial out toggles so a stale bit cannot pass
	wire logic      so_line  = spi_so_oe ? spi_so : clk_sys_i;
	wire logic      irq_line = irq_n_oe ? irq_n : 1'b1;
	int        n_errors  = 0;
	int        cmp_count = 0;
	int        seed      = 32'h970f;
	gxp_byte_t rst_tab [12];
	gxp_byte_t regv [12];

	always #50 clk_sys_i = ~clk_sys_i;

	gxp_port #(.FLT_CYC(FLT_CYC_DEF)) dut (
		.clk_sys_i    (clk_sys_i),
		.rst_n_i      (rst_n_i),
		.spi_clk_i    (spi_clk),
		.spi_cs_n_i   (spi_cs_n),
		.spi_si_i     (spi_si),
		.spi_so_o     (spi_so),
		.spi_so_oe_o  (spi_so_oe),
		.io_pins_i    (pin_lvl),
		.io_pins_o    (pins_o),
		.io_pins_oe_o (pins_oe),
		.pullup_en_o  (pu_en),
		.irq_n_o      (irq_n),
		.irq_n_oe_o   (irq_n_oe)
	);

	gxp_spi_host host (
		.spi_clk_o  (spi_clk),
		.spi_cs_n_o (spi_cs_n),
		.spi_si_o   (spi_si),
		.spi_so_i   (so_line)
	);

	function automatic gxp_byte_t exp_state(gxp_byte_t dir, gxp_byte_t inv, gxp_byte_t ol,
		gxp_byte_t ext);
		return (dir & (ext ^ inv)) | (~dir & ol);
	endfunction : exp_state

	task automatic wr(input logic [5:0] s, input gxp_byte_t d);
		gxp_byte_t x;
		host.xfer(1'b0, s, 1'($random(seed)), d, x);
	endtask : wr

	task automatic rd(input logic [5:0] s, output gxp_byte_t d);
		host.xfer(1'b1, s, 1'($random(seed)), 8'($random(seed)), d);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : cyc

	task automatic setpin(input logic [2:0] p, input logic lv);
		@(posedge clk_sys_i);
		ext_q[p] <= lv;
	endtask : setpin

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	initial begin
		#1_000_000;
		n_errors++;
		finish_test();
	end

	initial begin
		gxp_byte_t  r, d;
		logic [2:0] p;
		rst_tab = '{8'h00, RST_OUTPUT_LEVEL, RST_INPUT_INVERT, RST_PIN_DIRECTION,
			RST_PULLUP_ENABLE, RST_IRQ_ENABLE, RST_OUTPUT_HIZ, RST_IRQ_STATUS,
			RST_RISE_IRQ_SELECT, RST_FALL_IRQ_SELECT, RST_GLITCH_FILTER, 8'h00};
		ext_q <= 8'($random(seed));
		cyc(4);
		rst_n_i <= 1'b1;
		cyc(3);
		`CHK(pins_oe, NO_PINS)
		`CHK(pu_en, NO_PINS)
		`CHK(irq_line, 1'b1)
		for (int s = 1; s <= 11; s++) begin
			rd(6'(s), r);
			`CHK(r, rst_tab[s])
		end
		rd(REG_PIN_STATE, r);
		`CHK(r, ext_q)
		$display("test reset done");

		for (int s = 1; s <= 10; s++) begin
			d = 8'($random(seed));
			wr(6'(s), d);
			regv[s] = (s == 7) ? 8'h00 : d;
		end
		regv[11] = 8'h00;
		// writes to read-only and unmapped places
		wr(REG_PIN_STATE, 8'($random(seed)));
		wr(REG_IRQ_STATUS, ALL_PINS);
		wr(6'h0B, 8'($random(seed)));
		for (int s = 1; s <= 11; s++) begin
			rd(6'(s), r);
			`CHK(r, regv[s])
		end
		`CHK(pins_o, regv[1])
		`CHK(pins_oe, ~regv[3] & ~regv[6])
		`CHK(pu_en, regv[4])
		rd(REG_PIN_STATE, r);
		`CHK(r, exp_state(regv[3], regv[2], regv[1], ext_q))
		$display("test registers done");

		wr(REG_PIN_DIRECTION, ALL_PINS);
		wr(REG_INPUT_INVERT, NO_PINS);
		wr(REG_GLITCH_FILTER, NO_PINS);
		for (int m = 0; m < 4; m++) begin
			p = 3'($random(seed));
			wr(REG_IRQ_ENABLE, 8'h01 << p);
			wr(REG_RISE_IRQ_SELECT, m[1] ? ALL_PINS : NO_PINS);
			wr(REG_FALL_IRQ_SELECT, m[0] ? ALL_PINS : NO_PINS);
			setpin(p, 1'b0);
			cyc(20);
			rd(REG_PIN_STATE, r);
			setpin(p, 1'b1);
			cyc(10);
			rd(REG_IRQ_STATUS, r);
			`CHK(r, (m != 1) ? 8'h01 << p : NO_PINS)
			setpin(p, 1'b0);
			cyc(10);
			rd(REG_IRQ_STATUS, r);
			`CHK(r, (m != 0) ? 8'h01 << p : NO_PINS)
			`CHK(irq_line, 1'(m == 0))
			rd(REG_PIN_STATE, r);
			rd(REG_IRQ_STATUS, r);
			`CHK(r, NO_PINS)
		end
		$display("test edge modes done");

		// an output pin toggling must stay silent
		wr(REG_PIN_DIRECTION, ~(8'h01 << p));
		wr(REG_OUTPUT_HIZ, NO_PINS);
		wr(REG_OUTPUT_LEVEL, NO_PINS);
		wr(REG_OUTPUT_LEVEL, ALL_PINS);
		setpin(p, 1'b1);
		cyc(10);
		rd(REG_IRQ_STATUS, r);
		`CHK(r, NO_PINS)
		setpin(p, 1'b0);
		wr(REG_PIN_DIRECTION, ALL_PINS);
		wr(REG_FALL_IRQ_SELECT, NO_PINS);
		$display("test output silent done");

		// short pulse filtered, same pulse in bypass, long pulse passes the filter
		for (int k = 0; k < 3; k++) begin
			wr(REG_GLITCH_FILTER, k == 1 ? NO_PINS : ALL_PINS);
			rd(REG_PIN_STATE, r);
			setpin(p, 1'b1);
			// two samples make a 200 ns pulse, below the rejection limit
			cyc(k == 2 ? 11 : 1);
			setpin(p, 1'b0);
			cyc(20);
			rd(REG_IRQ_STATUS, r);
			`CHK(r, k == 0 ? NO_PINS : 8'h01 << p)
		end
		$display("test filter done");
		finish_test();
	end
endmodule : gxp_port_tb_top
